// *** logic/mcr_pkg.sv ***
// Purpose: Shared constants for the channel message receiver.
// Assumes: 25 MHz system clock, 31250 baud serial input, 8N1 framing.
// Notes:   Register offsets are byte addresses on the 32-bit bus.
package mcr_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned BAUD_HZ      = 31_250;
  localparam int unsigned BIT_CYCLES   = CLK_HZ / BAUD_HZ;
  localparam int unsigned SENSE_MS     = 420;
  localparam int unsigned SENSE_CYCLES = (CLK_HZ / 1000) * SENSE_MS;
  localparam int unsigned NPARTS       = 3;

  // Status nibbles and single status bytes.
  localparam logic [3:0] ST_CC    = 4'hB;
  localparam logic [3:0] ST_PROG  = 4'hC;
  localparam logic [3:0] ST_PRESS = 4'hD;
  localparam logic [3:0] ST_BEND  = 4'hE;
  localparam logic [7:0] BYTE_SYS = 8'hF0;
  localparam logic [7:0] BYTE_RT  = 8'hF8;
  localparam logic [7:0] BYTE_SENSE = 8'hFE;

  // Controller numbers.
  localparam logic [6:0] CC_MOD       = 7'h01;
  localparam logic [6:0] CC_DATA_MSB  = 7'h06;
  localparam logic [6:0] CC_DATA_LSB  = 7'h26;
  localparam logic [6:0] CC_HOLD      = 7'h40;
  localparam logic [6:0] CC_BRAKE     = 7'h51;
  localparam logic [6:0] CC_RPN_LSB   = 7'h64;
  localparam logic [6:0] CC_RPN_MSB   = 7'h65;
  localparam logic [6:0] CC_SOUND_OFF = 7'h78;
  localparam logic [6:0] CC_RESET_CTL = 7'h79;
  localparam logic [6:0] CC_NOTES_OFF = 7'h7B;

  // Values and limits.
  localparam logic [6:0]  VAL_HALF     = 7'h40;
  localparam logic [6:0]  VAL_ZERO     = 7'h00;
  localparam logic [6:0]  RPN_NULL     = 7'h7F;
  localparam logic [6:0]  RPN_BEND_RNG = 7'h00;
  localparam logic [6:0]  RPN_FINE     = 7'h01;
  localparam logic [6:0]  RPN_COARSE   = 7'h02;
  localparam logic [6:0]  RANGE_MAX    = 7'h18;
  localparam logic [4:0]  RANGE_RESET  = 5'h02;
  localparam logic [13:0] FINE_MIN     = 14'h1000;
  localparam logic [13:0] FINE_CENTER  = 14'h2000;
  localparam logic [13:0] FINE_MAX     = 14'h3000;
  localparam logic [6:0]  COARSE_MIN   = 7'h10;
  localparam logic [6:0]  COARSE_CENTER = 7'h40;
  localparam logic [6:0]  COARSE_MAX   = 7'h70;
  localparam logic [13:0] BEND_CENTER  = 14'h2000;
  localparam logic [6:0]  REG_MAX      = 7'h3F;
  localparam logic [6:0]  TONE_MAX     = 7'h07;

  // Register byte offsets.
  localparam logic [7:0] A_CFG    = 8'h00;
  localparam logic [7:0] A_ORGAN  = 8'h04;
  localparam logic [7:0] A_TUNE   = 8'h08;
  localparam logic [7:0] A_HOLD   = 8'h0C;
  localparam logic [7:0] A_PART_A = 8'h10;
  localparam logic [7:0] A_PART_B = 8'h14;
  localparam logic [7:0] A_PART_STEP = 8'h08;

  // Configuration reset: control ch 1, orchestral ch 4/5/6, both switches on.
  localparam logic [17:0] CFG_RESET = 18'h3_5430;

  typedef enum logic [1:0] {
    MCR_RX_IDLE  = 2'b00,
    MCR_RX_START = 2'b01,
    MCR_RX_DATA  = 2'b10,
    MCR_RX_STOP  = 2'b11
  } mcr_rx_e;
endpackage : mcr_pkg

// *** logic/mcr_receiver.sv ***
// Purpose: Serial channel message receiver with controller state and AHB-Lite registers.
// Assumes: One clock at 25 MHz; serial line idles high; zero wait state bus slave.
// Notes:   Decoded state is read over the bus; note actions leave as pulses.
`timescale 1ns/1ps

// What this block does
// - Controller 81 sets rotary brake: below 64 spin, 64 and up brake.
// - Rotary brake is taken only on the control channel setting.
// - Rotary brake never acts on orchestral tone parts.
// - Rotary brake is ignored while the general controller switch is off.
// - Controllers 101 and 100 select the parameter, in either order.
// - Data entry 6 and 38 on the selecting channel changes that parameter.
// - Parameter 0,0 sets bend range from upper byte, at most 24.
// - Parameter 0,1 sets fine tuning from 14 bits, limited 1000H to 3000H.
// - Parameter 0,2 sets coarse tuning from upper byte, limited 10H to 70H.
// - Bend range and tuning parameters never act on the organ part.
// - Null selection makes later data entry change nothing.
// - Program change on the control channel recalls registrations 0 to 63.
// - Program change on an orchestral channel selects tones 0 to 7.
// - Program changes are ignored while the program change switch is off.
// - Channel pressure is taken only for orchestral tone parts.
// - Pitch bend is a 14-bit value, taken only for orchestral parts.
// - Controller 120 value 0 silences every note on that channel.
// - Controller 121 value 0 centres bend, zeroes modulation, releases hold.
// - Controller 123 value 0 releases notes, deferred while hold is on.
// - After FEH, a gap over 420 ms silences and releases all, resets bend, modulation and hold, and stops monitoring.
// - Controller 64 is the hold: below 64 off, 64 and up on.
module mcr_receiver #(
  parameter int unsigned SENSE_TIMEOUT = mcr_pkg::SENSE_CYCLES,
  parameter int unsigned BIT_TIME      = mcr_pkg::BIT_CYCLES
) (
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        midi_rx_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  output logic             rotary_brake_out,
  output logic [5:0]       registration_out,
  output logic             registration_load_out,
  output logic             silence_out,
  output logic             release_out,
  output logic             evt_all_out,
  output logic [3:0]       evt_chan_out,
  output logic             sensing_out
);
  import mcr_pkg::*;

  localparam int unsigned BW = $clog2(BIT_TIME);
  localparam int unsigned SW = $clog2(SENSE_TIMEOUT + 1);
  localparam logic [BW-1:0] BIT_LAST  = BW'(BIT_TIME - 1);
  localparam logic [BW-1:0] HALF_LAST = BW'(BIT_TIME / 2 - 1);
  localparam logic [SW-1:0] SENSE_LAST = SW'(SENSE_TIMEOUT - 1);

  // ---------------- Serial receive ----------------
  logic          rx_meta;
  logic          rx_sync;
  mcr_rx_e       rx_state;
  logic [BW-1:0] baud_cnt;
  logic [2:0]    bit_idx;
  logic [7:0]    shift;
  logic          byte_valid;
  logic [7:0]    byte_data;
  logic          baud_tick;

  always_ff @(posedge ref_clk_in) begin
    rx_meta <= midi_rx_in;
    rx_sync <= rx_meta;
  end

  assign baud_tick = (baud_cnt == '0);

  // Start bit is checked at mid bit, so a glitch on the line is not taken as a byte.
  always_ff @(posedge ref_clk_in) begin
    byte_valid <= 1'b0;
    if (srst_in) begin
      rx_state  <= MCR_RX_IDLE;
      baud_cnt  <= '0;
      bit_idx   <= 3'h0;
      shift     <= 8'h00;
      byte_data <= 8'h00;
    end else begin
      if (!baud_tick) begin
        baud_cnt <= baud_cnt - 1'b1;
      end
      unique case (rx_state)
        MCR_RX_IDLE: begin
          if (!rx_sync) begin
            rx_state <= MCR_RX_START;
            baud_cnt <= HALF_LAST;
          end
        end
        MCR_RX_START: begin
          if (baud_tick) begin
            rx_state <= rx_sync ? MCR_RX_IDLE : MCR_RX_DATA;
            baud_cnt <= BIT_LAST;
            bit_idx  <= 3'h0;
          end
        end
        MCR_RX_DATA: begin
          if (baud_tick) begin
            shift    <= {rx_sync, shift[7:1]};
            baud_cnt <= BIT_LAST;
            bit_idx  <= bit_idx + 1'b1;
            if (bit_idx == 3'h7) begin
              rx_state <= MCR_RX_STOP;
            end
          end
        end
        MCR_RX_STOP: begin
          if (baud_tick) begin
            rx_state <= MCR_RX_IDLE;
            if (rx_sync) begin
              byte_valid <= 1'b1;
              byte_data  <= shift;
            end
          end
        end
      endcase
    end
  end

  // ---------------- Message assembly ----------------
  logic [7:0] run_status;
  logic [6:0] first_data;
  logic       have_first;
  logic       msg_valid;
  logic [3:0] msg_kind;
  logic [3:0] msg_chan;
  logic [6:0] msg_d1;
  logic [6:0] msg_d2;
  logic       two_data;

  assign two_data = (run_status[7:4] != ST_PROG) && (run_status[7:4] != ST_PRESS);

  // Running status is kept; realtime bytes pass through without disturbing it.
  always_ff @(posedge ref_clk_in) begin
    msg_valid <= 1'b0;
    if (srst_in) begin
      run_status <= 8'h00;
      first_data <= VAL_ZERO;
      have_first <= 1'b0;
      msg_kind   <= 4'h0;
      msg_chan   <= 4'h0;
      msg_d1     <= VAL_ZERO;
      msg_d2     <= VAL_ZERO;
    end else if (byte_valid) begin
      if (byte_data[7]) begin
        if (byte_data < BYTE_RT) begin
          run_status <= (byte_data >= BYTE_SYS) ? 8'h00 : byte_data;
          have_first <= 1'b0;
        end
      end else if (run_status[7]) begin
        if (two_data && !have_first) begin
          first_data <= byte_data[6:0];
          have_first <= 1'b1;
        end else begin
          msg_valid  <= 1'b1;
          msg_kind   <= run_status[7:4];
          msg_chan   <= run_status[3:0];
          msg_d1     <= two_data ? first_data : byte_data[6:0];
          msg_d2     <= byte_data[6:0];
          have_first <= 1'b0;
        end
      end
    end
  end

  // ---------------- Configuration and decode ----------------
  logic [17:0] cfg;
  logic [3:0]  control_channel_setting;
  logic [3:0]  orchestral_channel_setting [NPARTS];
  logic        general_controller_rx_switch;
  logic        program_change_rx_switch;
  logic        is_cc;
  logic        on_ctl_ch;
  logic [NPARTS-1:0] part_hit;
  logic        on_orch;
  logic        sense_timeout;

  assign control_channel_setting      = cfg[3:0];
  assign general_controller_rx_switch = cfg[16];
  assign program_change_rx_switch     = cfg[17];
  assign is_cc     = msg_valid && (msg_kind == ST_CC);
  assign on_ctl_ch = (msg_chan == control_channel_setting);

  for (genvar p = 0; p < NPARTS; p++) begin : g_part_hit
    assign orchestral_channel_setting[p] = cfg[4*p+7 -: 4];
    assign part_hit[p] = (msg_chan == orchestral_channel_setting[p]);
  end
  assign on_orch = |part_hit;

  // ---------------- Organ controls and registrations ----------------
  always_ff @(posedge ref_clk_in) begin
    registration_load_out <= 1'b0;
    if (srst_in) begin
      rotary_brake_out <= 1'b0;
      registration_out <= 6'h00;
    end else begin
      if (is_cc && msg_d1 == CC_BRAKE && on_ctl_ch && !on_orch
          && general_controller_rx_switch) begin
        rotary_brake_out <= (msg_d2 >= VAL_HALF);
      end
      if (msg_valid && msg_kind == ST_PROG && on_ctl_ch && program_change_rx_switch
          && msg_d1 <= REG_MAX) begin
        registration_out      <= msg_d1[5:0];
        registration_load_out <= 1'b1;
      end
    end
  end

  // ---------------- Parameter selection and tuning ----------------
  logic [6:0]  rpn_msb;
  logic [6:0]  rpn_lsb;
  logic [3:0]  rpn_chan;
  logic        rpn_null;
  logic        entry_msb;
  logic        entry_lsb;
  logic [13:0] fine_tune;
  logic [6:0]  coarse_tune;
  logic [13:0] next_fine;

  assign rpn_null  = (rpn_msb == RPN_NULL) && (rpn_lsb == RPN_NULL);
  // data entry only on the selecting channel and not after null
  assign entry_msb = is_cc && msg_d1 == CC_DATA_MSB && msg_chan == rpn_chan && !rpn_null;
  assign entry_lsb = is_cc && msg_d1 == CC_DATA_LSB && msg_chan == rpn_chan && !rpn_null;

  always_comb begin
    next_fine = entry_msb ? {msg_d2, fine_tune[6:0]} : {fine_tune[13:7], msg_d2};
    if (next_fine < FINE_MIN) begin
      next_fine = FINE_MIN;
    end else if (next_fine > FINE_MAX) begin
      next_fine = FINE_MAX;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rpn_msb <= RPN_NULL;
      rpn_lsb <= RPN_NULL;
      rpn_chan <= 4'h0;
    end else if (is_cc) begin
      if (msg_d1 == CC_RPN_MSB) begin
        rpn_msb  <= msg_d2;
        rpn_chan <= msg_chan;
      end else if (msg_d1 == CC_RPN_LSB) begin
        rpn_lsb  <= msg_d2;
        rpn_chan <= msg_chan;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      fine_tune   <= FINE_CENTER;
      coarse_tune <= COARSE_CENTER;
    end else if (on_orch && rpn_msb == RPN_BEND_RNG) begin
      if ((entry_msb || entry_lsb) && rpn_lsb == RPN_FINE) begin
        fine_tune <= next_fine;
      end
      // coarse tuning from upper byte, clamped
      if (entry_msb && rpn_lsb == RPN_COARSE) begin
        coarse_tune <= (msg_d2 < COARSE_MIN) ? COARSE_MIN :
                       (msg_d2 > COARSE_MAX) ? COARSE_MAX : msg_d2;
      end
    end
  end

  // ---------------- Orchestral part state ----------------
  logic [13:0] bend     [NPARTS];
  logic [4:0]  bend_rng [NPARTS];
  logic [2:0]  tone     [NPARTS];
  logic [6:0]  pressure [NPARTS];
  logic [6:0]  modul    [NPARTS];
  logic        ctl_reset;

  assign ctl_reset = is_cc && msg_d1 == CC_RESET_CTL && msg_d2 == VAL_ZERO;

  for (genvar p = 0; p < NPARTS; p++) begin : g_part
    always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
        bend[p]     <= BEND_CENTER;
        bend_rng[p] <= RANGE_RESET;
        tone[p]     <= 3'h0;
        pressure[p] <= VAL_ZERO;
        modul[p]    <= VAL_ZERO;
      end else if (sense_timeout) begin
        bend[p]  <= BEND_CENTER;
        modul[p] <= VAL_ZERO;
      end else if (msg_valid && part_hit[p]) begin
        // bend from two 7-bit bytes, low byte first
        if (msg_kind == ST_BEND) begin
          bend[p] <= {msg_d2, msg_d1};
        end
        if (msg_kind == ST_PRESS) begin
          pressure[p] <= msg_d1;
        end
        if (msg_kind == ST_PROG && program_change_rx_switch && msg_d1 <= TONE_MAX) begin
          tone[p] <= msg_d1[2:0];
        end
        if (is_cc && msg_d1 == CC_MOD) begin
          modul[p] <= msg_d2;
        end
        if (ctl_reset) begin
          bend[p]  <= BEND_CENTER;
          modul[p] <= VAL_ZERO;
        end
        // bend range, clamped, low byte ignored
        if (entry_msb && rpn_msb == RPN_BEND_RNG && rpn_lsb == RPN_BEND_RNG) begin
          bend_rng[p] <= (msg_d2 > RANGE_MAX) ? RANGE_MAX[4:0] : msg_d2[4:0];
        end
      end
    end
  end

  // ---------------- Hold, note release and silencing ----------------
  logic [15:0] hold;
  logic [15:0] pend_release;
  logic        hold_msg;
  logic        notes_off;
  logic        sound_off;

  assign hold_msg  = is_cc && msg_d1 == CC_HOLD;
  assign notes_off = is_cc && msg_d1 == CC_NOTES_OFF && msg_d2 == VAL_ZERO;
  assign sound_off = is_cc && msg_d1 == CC_SOUND_OFF && msg_d2 == VAL_ZERO;

  always_ff @(posedge ref_clk_in) begin
    silence_out <= 1'b0;
    release_out <= 1'b0;
    evt_all_out <= 1'b0;
    if (srst_in) begin
      hold         <= 16'h0000;
      pend_release <= 16'h0000;
      evt_chan_out <= 4'h0;
    end else if (sense_timeout) begin
      // all-channel sound off, notes off, controllers reset
      hold         <= 16'h0000;
      pend_release <= 16'h0000;
      silence_out  <= 1'b1;
      release_out  <= 1'b1;
      evt_all_out  <= 1'b1;
    end else if (msg_valid) begin
      evt_chan_out <= msg_chan;
      if (sound_off) begin
        silence_out            <= 1'b1;
        pend_release[msg_chan] <= 1'b0;
      end else if (hold_msg || ctl_reset) begin
        hold[msg_chan] <= hold_msg && (msg_d2 >= VAL_HALF);
        if (!(hold_msg && msg_d2 >= VAL_HALF) && pend_release[msg_chan]) begin
          release_out            <= 1'b1;
          pend_release[msg_chan] <= 1'b0;
        end
      // release now, or defer while held
      end else if (notes_off) begin
        if (hold[msg_chan]) begin
          pend_release[msg_chan] <= 1'b1;
        end else begin
          release_out <= 1'b1;
        end
      end
    end
  end

  // ---------------- Active sensing supervisor ----------------
  logic [SW-1:0] sense_cnt;

  assign sense_timeout = sensing_out && (sense_cnt == SENSE_LAST) && !byte_valid;

  // Any received byte counts as traffic, so a long message never trips the timer.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sensing_out <= 1'b0;
      sense_cnt   <= '0;
    end else if (byte_valid) begin
      sense_cnt <= '0;
      if (byte_data == BYTE_SENSE) begin
        sensing_out <= 1'b1;
      end
    end else if (sense_timeout) begin
      sensing_out <= 1'b0;
      sense_cnt   <= '0;
    end else if (sensing_out) begin
      sense_cnt <= sense_cnt + 1'b1;
    end
  end

  // ---------------- AHB-Lite slave ----------------
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       addr_take;
  logic [31:0] read_mux;
  logic [7:0]  ra;

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign addr_take     = hsel_in && hready_in && htrans_in[1];
  assign ra            = haddr_in[7:0];

  always_comb begin
    read_mux = 32'h0000_0000;
    if (ra == A_CFG) begin
      read_mux = {14'h0000, cfg};
    end else if (ra == A_ORGAN) begin
      read_mux = {16'h0000, 1'b0, sensing_out, registration_out, 7'h00, rotary_brake_out};
    end else if (ra == A_TUNE) begin
      read_mux = {9'h000, coarse_tune, 2'h0, fine_tune};
    end else if (ra == A_HOLD) begin
      read_mux = {pend_release, hold};
    end
    for (int p = 0; p < NPARTS; p++) begin
      if (ra == A_PART_A + 8'(p) * A_PART_STEP) begin
        read_mux = {5'h00, tone[p], 3'h0, bend_rng[p], 2'h0, bend[p]};
      end else if (ra == A_PART_B + 8'(p) * A_PART_STEP) begin
        read_mux = {17'h00000, modul[p], 1'b0, pressure[p]};
      end
    end
  end

  // Read data is captured at the address phase, so the slave never inserts waits.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      hrdata_out <= 32'h0000_0000;
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
    end else begin
      wr_pend <= addr_take && hwrite_in;
      wr_addr <= ra;
      if (addr_take && !hwrite_in) begin
        hrdata_out <= read_mux;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cfg <= CFG_RESET;
    end else if (wr_pend && wr_addr == A_CFG) begin
      cfg <= hwdata_in[17:0];
    end
  end
endmodule : mcr_receiver

// *** dv/mcr_receiver_chk.sv ***
// Purpose: Port checks for the channel message receiver.
// Assumes: One clock domain, reset synchronous and active high.
// Notes:   Bound to every receiver instance.
`timescale 1ns/1ps
module mcr_receiver_chk #(
  parameter int unsigned SENSE_TIMEOUT = 2000
) (
  input wire logic       ref_clk_in,
  input wire logic       srst_in,
  input wire logic       midi_rx_in,
  input wire logic       rotary_brake_out,
  input wire logic [5:0] registration_out,
  input wire logic       registration_load_out,
  input wire logic       silence_out,
  input wire logic       release_out,
  input wire logic       evt_all_out,
  input wire logic       sensing_out
);
  int unsigned quiet;

  // The gap timer restarts after the last low bit, so this is a lower bound on the gap.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !midi_rx_in) begin
      quiet <= 0;
    end else if (quiet < SENSE_TIMEOUT + 8) begin
      quiet <= quiet + 1;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_halt;
    !sensing_out ##1 !evt_all_out;
  endsequence

  a_all_both:
    assert property (evt_all_out |-> silence_out && release_out) else $error("timeout half");
  a_halt_after:
    assert property (evt_all_out |-> s_halt) else $error("monitoring kept on");
  a_armed_first:
    assert property (evt_all_out |-> $past(sensing_out)) else $error("timeout unarmed");
  a_gap_long:
    assert property (evt_all_out |-> quiet > SENSE_TIMEOUT - 4) else $error("timeout early");
  a_sil_pulse:
    assert property (silence_out |=> !silence_out) else $error("silence too long");
  a_rel_pulse:
    assert property (release_out |=> !release_out) else $error("release too long");
  a_load_pulse:
    assert property (registration_load_out |=> !registration_load_out) else $error("load long");
  a_reg_by_load:
    assert property ($changed(registration_out) |-> registration_load_out) else $error("reg moved");
  a_brake_alone:
    assert property ($changed(rotary_brake_out) |-> !silence_out && !registration_load_out)
      else $error("brake moved");
endmodule : mcr_receiver_chk

bind mcr_receiver mcr_receiver_chk #(.SENSE_TIMEOUT(SENSE_TIMEOUT)) u_chk (
  .ref_clk_in, .srst_in, .midi_rx_in, .rotary_brake_out, .registration_out,
  .registration_load_out, .silence_out, .release_out, .evt_all_out, .sensing_out
);

// *** dv/mcr_midi_src.sv ***
// Purpose: Serial source in place of the sending instrument.
// Assumes: 8N1 framing; the line idles high.
// Notes:   The bench sends bytes one at a time with send_byte.
`timescale 1ns/1ps
module mcr_midi_src #(
  parameter int unsigned BT = 16
) (
  input  wire logic ref_clk_in,
  output logic      midi_out
);
  initial midi_out = 1'b1;

  // Start bit, data low bit first, then a stop bit that leaves the line resting high.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      midi_out <= f[i];
      repeat (BT) @(posedge ref_clk_in);
    end
  endtask : send_byte
endmodule : mcr_midi_src

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the channel message receiver.
// Assumes: Short bit time and sensing timeout; zero wait state bus.
// Notes:   State is judged by register reads and output pulses.
`timescale 1ns/1ps
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  import mcr_pkg::*;
  localparam int unsigned BT = 16;
  localparam int unsigned ST = 2000;
  logic        ref_clk_in, srst_in, midi_rx_in, hsel_in, hwrite_in, hready_in;
  logic        hreadyout_out, hresp_out, rotary_brake_out, registration_load_out;
  logic        silence_out, release_out, evt_all_out, sensing_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [5:0]  registration_out;
  logic [3:0]  evt_chan_out, last_ch;
  int          n_errors, compares, n_sil, n_rel, n_all, n_load, cyc;

  assign hready_in = hreadyout_out;
  mcr_receiver #(.SENSE_TIMEOUT(ST), .BIT_TIME(BT)) uut (.ref_clk_in, .srst_in, .midi_rx_in,
    .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in,
    .hreadyout_out, .hresp_out, .hrdata_out, .rotary_brake_out, .registration_out,
    .registration_load_out, .silence_out, .release_out, .evt_all_out, .evt_chan_out,
    .sensing_out);
  mcr_midi_src #(.BT(BT)) src (.ref_clk_in, .midi_out(midi_rx_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk_in) begin
    if (silence_out === 1'b1) n_sil++;
    if (release_out === 1'b1) n_rel++;
    if (evt_all_out === 1'b1) n_all++;
    if (registration_load_out === 1'b1) n_load++;
    if ((silence_out | release_out) === 1'b1) last_ch = evt_chan_out;
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      print_verdict();
    end
  end

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel_in <= 1'b1;
    haddr_in <= {24'h000000, a};
    htrans_in <= 2'b10;
    hwrite_in <= w;
    @(posedge ref_clk_in);
    while (hready_in !== 1'b1) @(posedge ref_clk_in);
    htrans_in <= 2'b00;
    hsel_in <= 1'b0;
    hwdata_in <= d;
    @(posedge ref_clk_in);
    while (hready_in !== 1'b1) @(posedge ref_clk_in);
    q = hrdata_out;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task chk(input string n, input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CK(n, e, q & m)
  endtask : chk

  task msg(input logic [7:0] a, b, c, input int n = 3);
    src.send_byte(a);
    if (n > 1) src.send_byte(b);
    if (n > 2) src.send_byte(c);
    repeat (6) @(posedge ref_clk_in);
  endtask : msg

  task t_regs();
    chk("cfg", A_CFG, 32'hFFFFFFFF, 32'h35430);
    chk("organ", A_ORGAN, 32'hFFFFFFFF, 32'h0);
    chk("hole", 8'h40, 32'hFFFFFFFF, 32'h0);
    `CK("okay", 1'b0, hresp_out)
  endtask : t_regs

  task t_brake();
    msg(8'hB0, 8'h51, 8'h40);
    `CK("brake_pin", 1'b1, rotary_brake_out)
    msg(8'hB0, 8'h51, 8'h3F);
    chk("spin", A_ORGAN, 32'h1, 32'h0);
    msg(8'hB1, 8'h51, 8'h7F);
    chk("other_ch", A_ORGAN, 32'h1, 32'h0);
    wr(A_CFG, 32'h25430);
    msg(8'hB0, 8'h51, 8'h7F);
    chk("sw_off", A_ORGAN, 32'h1, 32'h0);
    wr(A_CFG, 32'h35433);
    msg(8'hB3, 8'h51, 8'h7F);
    chk("orch", A_ORGAN, 32'h1, 32'h0);
    wr(A_CFG, 32'h35430);
  endtask : t_brake

  task t_rpn();
    msg(8'hB3, 8'h06, 8'h05);
    chk("rng_rst", A_PART_A, 32'h1F0000, 32'h20000);
    msg(8'hB3, 8'h64, 8'h00);
    msg(8'hB3, 8'h65, 8'h00);
    msg(8'hB3, 8'h06, 8'h05);
    chk("rng", A_PART_A, 32'h1F0000, 32'h50000);
    msg(8'hB3, 8'h65, 8'h00);
    msg(8'hB3, 8'h64, 8'h02);
    msg(8'hB3, 8'h06, 8'h50);
    chk("coarse", A_TUNE, 32'h7F0000, 32'h500000);
    msg(8'hB3, 8'h64, 8'h01);
    msg(8'hB3, 8'h06, 8'h50);
    msg(8'hB3, 8'h26, 8'h00);
    msg(8'hB4, 8'h26, 8'h11);
    chk("fine", A_TUNE, 32'h3FFF, 32'h2800);
    msg(8'hB3, 8'h06, 8'h7F);
    chk("fine_max", A_TUNE, 32'h3FFF, 32'h3000);
    msg(8'hB3, 8'h65, 8'h7F);
    msg(8'hB3, 8'h64, 8'h7F);
    msg(8'hB3, 8'h06, 8'h20);
    chk("null", A_TUNE, 32'h7F3FFF, 32'h503000);
    msg(8'hB0, 8'h64, 8'h02);
    msg(8'hB0, 8'h65, 8'h00);
    msg(8'hB0, 8'h06, 8'h30);
    chk("organ_ch", A_TUNE, 32'h7F0000, 32'h500000);
  endtask : t_rpn

  task t_prog();
    msg(8'hC0, 8'h2A, 8'h00, 2);
    `CK("reg", 6'h2A, registration_out)
    `CK("load", 1, n_load)
    msg(8'hC3, 8'h05, 8'h00, 2);
    chk("tone_up", A_PART_A, 32'h7000000, 32'h5000000);
    msg(8'hC5, 8'h07, 8'h00, 2);
    chk("tone_pd", 8'h20, 32'h7000000, 32'h7000000);
    wr(A_CFG, 32'h15430);
    msg(8'hC0, 8'h11, 8'h00, 2);
    `CK("reg_off", 6'h2A, registration_out)
    `CK("load_off", 1, n_load)
    wr(A_CFG, 32'h35430);
  endtask : t_prog

  task t_pb();
    msg(8'hD3, 8'h55, 8'h00, 2);
    chk("press", A_PART_B, 32'h7F, 32'h55);
    msg(8'hE4, 8'h7F, 8'h7F);
    chk("bend", 8'h18, 32'h3FFF, 32'h3FFF);
    msg(8'hE3, 8'h00, 8'h00);
    chk("bend_lo", A_PART_A, 32'h3FFF, 32'h0);
    msg(8'h10, 8'h20, 8'h00, 2);
    chk("bend_run", A_PART_A, 32'h3FFF, 32'h1010);
  endtask : t_pb

  task t_modes();
    msg(8'hB2, 8'h78, 8'h00);
    `CK("sil", 1, n_sil)
    `CK("sil_ch", 4'h2, last_ch)
    msg(8'hB2, 8'h40, 8'h7F);
    msg(8'hB2, 8'h7B, 8'h00);
    `CK("held", 0, n_rel)
    chk("pend", A_HOLD, 32'h40004, 32'h40004);
    msg(8'hB2, 8'h79, 8'h00);
    `CK("rel", 1, n_rel)
    chk("hold_off", A_HOLD, 32'h40004, 32'h0);
    msg(8'hB2, 8'h7B, 8'h00);
    `CK("rel_now", 2, n_rel)
    msg(8'hB3, 8'h01, 8'h33);
    chk("mod_set", A_PART_B, 32'h7F00, 32'h3300);
    msg(8'hB3, 8'h79, 8'h00);
    chk("bend_ctr", A_PART_A, 32'h3FFF, 32'h2000);
    chk("mod", A_PART_B, 32'h7F00, 32'h0);
  endtask : t_modes

  task t_sense();
    msg(8'hB2, 8'h40, 8'h7F);
    msg(8'hFE, 8'h00, 8'h00, 1);
    chk("sensing", A_ORGAN, 32'h4000, 32'h4000);
    `CK("sense_pin", 1'b1, sensing_out)
    repeat (ST + 100) @(posedge ref_clk_in);
    `CK("all", 1, n_all)
    `CK("all_rel", 3, n_rel)
    `CK("all_sil", 2, n_sil)
    chk("stopped", A_ORGAN, 32'h4000, 32'h0);
    chk("hold_clr", A_HOLD, 32'h4, 32'h0);
  endtask : t_sense

  initial begin
    srst_in = 1'b1;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'b00;
    hwrite_in = 1'b0;
    hsize_in = 3'b010;
    hwdata_in = 32'h0;
    repeat (12) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge ref_clk_in);
    t_regs();
    t_brake();
    t_rpn();
    t_prog();
    t_pb();
    t_modes();
    t_sense();
    print_verdict();
  end
endmodule : tb
